// >>> has_pkg.sv
// Shared constants and carrier types for the host-side access spacing controller
package has_pkg;

    // Clock and wait times, each time in ns and its derived cycle count
    localparam int unsigned CLK_NS          = 20;
    localparam int unsigned WAIT_SHORT_NS   = 165;
    localparam int unsigned WAIT_LONG_NS    = 330;
    localparam int unsigned STROBE_LOW_NS   = 32;
    localparam int unsigned STROBE_HIGH_NS  = 13;
    localparam int unsigned CNT_W           = 5;
    localparam logic [4:0]  WAIT_SHORT_CYC  = 5'((WAIT_SHORT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0]  WAIT_LONG_CYC   = 5'((WAIT_LONG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0]  STROBE_LOW_CYC  = 5'((STROBE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0]  STROBE_HIGH_CYC = 5'((STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0]  CYCLE_CYC       = WAIT_SHORT_CYC;
    localparam logic [4:0]  CNT_MAX         = 5'h1f;

    // Spacing timers, one per kind of access that starts a wait
    localparam int unsigned TMR_WRITE  = 0;
    localparam int unsigned TMR_RXPOP  = 1;
    localparam int unsigned TMR_TXSTAT = 2;
    localparam int unsigned TMR_DROP   = 3;
    localparam int unsigned TMR_DPCTRL = 4;
    localparam int unsigned TMR_NUM    = 5;

    // Device byte offsets on its own address pins
    localparam logic [7:0] DEV_RX_DATA_FIFO   = 8'h00;
    localparam logic [7:0] DEV_RX_STATUS_FIFO = 8'h40;
    localparam logic [7:0] DEV_TX_STATUS_FIFO = 8'h48;
    localparam logic [7:0] DEV_IDENT          = 8'h50;
    localparam logic [7:0] DEV_BYTE_TEST      = 8'h64;
    localparam logic [7:0] DEV_RECEIVE_DATAPATH_CONTROL     = 8'h78;
    localparam logic [7:0] DEV_RX_FIFO_INFO   = 8'h7c;
    localparam logic [7:0] DEV_TX_FIFO_INFO   = 8'h80;
    localparam logic [7:0] DEV_PWR_MGMT_CTRL  = 8'h84;
    localparam logic [7:0] DEV_FREE_RUN       = 8'h9c;
    localparam logic [7:0] DEV_RX_DROP        = 8'ha0;
    localparam int unsigned FFWD_BIT          = 31;

    // Controller registers, Avalon word index
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_WDATA  = 3'h1;
    localparam logic [2:0] REG_CMD    = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_RDATA  = 3'h4;
    localparam logic [2:0] REG_STALL  = 3'h5;

    // Field positions and reset values
    localparam int unsigned CTRL_ENFORCE_BIT = 0;
    localparam int unsigned CTRL_DUMMY_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h1;
    localparam int unsigned CMD_ADDR_LSB     = 0;
    localparam int unsigned CMD_WRITE_BIT    = 8;
    localparam int unsigned CMD_FIFO_SEL_BIT = 9;

    // One device access as ordered by software
    typedef struct packed {
        logic        write;
        logic        fifo_sel;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } has_req_t;

    // Device pins driven by the controller
    typedef struct packed {
        logic        chip_select_n;
        logic        read_strobe_n;
        logic        write_strobe_n;
        logic        fifo_sel;
        logic [7:0]  addr;
        logic [31:0] data_out;
        logic        data_oe;
    } has_pins_t;

endpackage

// >>> has_gap_timer.sv
// Saturating cycle counters that measure time since each spacing event
`timescale 1ns/1ps
module has_gap_timer (
    input  wire logic                                     sys_clk,
    input  wire logic                                     rst,
    input  wire logic [has_pkg::TMR_NUM-1:0]              restart,
    output logic      [has_pkg::TMR_NUM-1:0][4:0]         count
);

    // One counter per event kind; reset means no wait pending
    for (genvar i = 0; i < has_pkg::TMR_NUM; i++) begin : g_tmr
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                count[i] <= has_pkg::CNT_MAX;
            end else if (restart[i]) begin
                count[i] <= 5'h00;
            end else if (count[i] != has_pkg::CNT_MAX) begin
                count[i] <= count[i] + 5'h01;
            end
        end
    end

endmodule

// >>> has_pin_cycle.sv
// One device bus cycle on the strobe pins, read or write
`timescale 1ns/1ps
module has_pin_cycle (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  has_pkg::has_req_t      req,
    input  wire logic [31:0]       data_in,
    output has_pkg::has_pins_t     pins,
    output logic                   busy,
    output logic                   done,
    output logic [31:0]            rdata
);

    typedef enum logic [1:0] {PC_IDLE, PC_SETUP, PC_LOW, PC_HIGH} has_pc_state_t;

    has_pc_state_t state;
    has_pc_state_t next_state;
    logic [4:0]    cyc;

    // Phase sequencing: setup, strobe low, strobe high up to the full cycle time
    assign done = (state == PC_HIGH) && (cyc == has_pkg::CYCLE_CYC - 5'h01);
    assign busy = (state != PC_IDLE);

    always_comb begin
        next_state = state;
        case (state)
            PC_IDLE:  if (start) next_state = PC_SETUP;
            PC_SETUP: next_state = PC_LOW;
            PC_LOW:   if (cyc == has_pkg::STROBE_LOW_CYC) next_state = PC_HIGH;
            PC_HIGH:  if (done) next_state = PC_IDLE;
            default:  next_state = PC_IDLE;
        endcase
    end

    // State, cycle count and pin drive
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= PC_IDLE;
            cyc   <= 5'h00;
            pins  <= '{chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1, default: '0};
            rdata <= 32'h0000_0000;
        end else begin
            state                <= next_state;
            cyc                  <= (state == PC_IDLE) ? 5'h00 : cyc + 5'h01;
            pins.chip_select_n   <= !(next_state == PC_LOW);
            pins.read_strobe_n   <= !(next_state == PC_LOW && !pins.data_oe);
            pins.write_strobe_n  <= !(next_state == PC_LOW && pins.data_oe);
            if (start && state == PC_IDLE) begin
                pins.addr     <= req.addr;
                pins.fifo_sel <= req.fifo_sel;
                pins.data_out <= req.wdata;
                pins.data_oe  <= req.write;
            end else if (done) begin
                pins.data_oe  <= 1'b0;
            end
            if (state == PC_LOW && next_state == PC_HIGH && !pins.data_oe) begin
                rdata <= data_in; // Strobe low two cycles, data long valid
            end
        end
    end

endmodule

// >>> has_host_ctrl.sv
// Host controller that spaces device accesses by their read-after-write and read-after-read waits
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module has_host_ctrl (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [2:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    output logic                      chip_select_n,
    output logic                      read_strobe_n,
    output logic                      write_strobe_n,
    output logic                      fifo_sel,
    output logic      [7:0]           dev_addr,
    input  wire logic [31:0]          dev_data_in,
    output logic      [31:0]          dev_data_out,
    output logic                      dev_data_oe
);

    typedef enum logic [1:0] {HM_IDLE, HM_WAIT, HM_RUN, HM_DUMMY} has_state_t;

    has_state_t                          state;
    logic                                ack;
    logic [1:0]                          ctrl;
    has_pkg::has_req_t                   cmd_req;
    logic [31:0]                         last_rdata;
    logic [31:0]                         stall_count;
    logic                                ffwd_pending;
    logic [has_pkg::TMR_NUM-1:0][4:0]    tmr_count;
    logic [has_pkg::TMR_NUM-1:0]         restart;
    has_pkg::has_req_t                   pin_req;
    has_pkg::has_pins_t                  pins;
    logic                                pin_busy;
    logic                                pin_done;
    logic [31:0]                         pin_rdata;

    // Bus slave decode: one wait cycle, then the answer; command writes stall while busy
    wire bus_req      = avs_read || avs_write;
    wire sel_ctrl     = (avs_address == has_pkg::REG_CTRL);
    wire sel_wdata    = (avs_address == has_pkg::REG_WDATA);
    wire sel_cmd      = (avs_address == has_pkg::REG_CMD);
    wire sel_status   = (avs_address == has_pkg::REG_STATUS);
    wire sel_rdata    = (avs_address == has_pkg::REG_RDATA);
    wire sel_stall    = (avs_address == has_pkg::REG_STALL);
    wire cmd_stall    = avs_write && sel_cmd && (state != HM_IDLE);
    wire wr_take      = avs_write && ack;
    wire cmd_take     = wr_take && sel_cmd;
    assign avs_waitrequest = bus_req && !ack;

    // Read data mux, unmapped words read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux = {30'h0000_0000, ctrl};
        end else if (sel_wdata) begin
            rd_mux = cmd_req.wdata;
        end else if (sel_cmd) begin
            rd_mux = {22'h00_0000, cmd_req.fifo_sel, cmd_req.write, cmd_req.addr};
        end else if (sel_status) begin
            rd_mux = {29'h0000_0000, ffwd_pending, (state == HM_WAIT) || (state == HM_DUMMY), state != HM_IDLE};
        end else if (sel_rdata) begin
            rd_mux = last_rdata;
        end else if (sel_stall) begin
            rd_mux = stall_count;
        end
    end

    // Bus answer and register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            ctrl         <= has_pkg::CTRL_RESET;
            cmd_req      <= '0;
        end else begin
            ack <= bus_req && !ack && !cmd_stall;
            if (avs_read && !ack) begin
                avs_readdata <= rd_mux;
            end
            if (wr_take && sel_ctrl) begin
                ctrl <= avs_writedata[1:0];
            end
            if (wr_take && sel_wdata) begin
                cmd_req.wdata <= avs_writedata;
            end
            if (cmd_take) begin
                cmd_req.addr     <= avs_writedata[has_pkg::CMD_ADDR_LSB +: 8];
                cmd_req.write    <= avs_writedata[has_pkg::CMD_WRITE_BIT];
                cmd_req.fifo_sel <= avs_writedata[has_pkg::CMD_FIFO_SEL_BIT];
            end
        end
    end

    // Classify the pending access by its target
    wire enforce      = ctrl[has_pkg::CTRL_ENFORCE_BIT];
    wire dummy_mode   = ctrl[has_pkg::CTRL_DUMMY_BIT];
    wire is_rd        = !cmd_req.write;
    wire is_fsel      = cmd_req.fifo_sel;
    wire rd_rx_pop    = is_rd && (is_fsel || cmd_req.addr == has_pkg::DEV_RX_DATA_FIFO
                                          || cmd_req.addr == has_pkg::DEV_RX_STATUS_FIFO);
    wire rd_rx_stat   = is_rd && !is_fsel && (cmd_req.addr == has_pkg::DEV_RX_STATUS_FIFO);
    wire rd_tx_stat   = is_rd && !is_fsel && (cmd_req.addr == has_pkg::DEV_TX_STATUS_FIFO);
    wire rd_rx_inf    = is_rd && !is_fsel && (cmd_req.addr == has_pkg::DEV_RX_FIFO_INFO);
    wire rd_tx_inf    = is_rd && !is_fsel && (cmd_req.addr == has_pkg::DEV_TX_FIFO_INFO);
    wire rd_drop      = is_rd && !is_fsel && (cmd_req.addr == has_pkg::DEV_RX_DROP);
    wire rd_dpctrl    = is_rd && !is_fsel && (cmd_req.addr == has_pkg::DEV_RECEIVE_DATAPATH_CONTROL);
    wire wr_dpctrl    = cmd_req.write && !is_fsel && (cmd_req.addr == has_pkg::DEV_RECEIVE_DATAPATH_CONTROL);
    wire zero_class   = is_fsel || cmd_req.addr == has_pkg::DEV_IDENT || cmd_req.addr == has_pkg::DEV_BYTE_TEST
                        || cmd_req.addr == has_pkg::DEV_RX_FIFO_INFO || cmd_req.addr == has_pkg::DEV_RX_DROP;
    wire long_class   = cmd_req.addr == has_pkg::DEV_PWR_MGMT_CTRL || cmd_req.addr == has_pkg::DEV_FREE_RUN;

    // Required wait after a write, in cycles, rounded up
    wire [4:0] need_write = (!is_rd || zero_class) ? 5'h00 :
                            long_class ? has_pkg::WAIT_LONG_CYC : has_pkg::WAIT_SHORT_CYC;

    // Every applicable wait must have elapsed; writes never wait
    wire ok_write  = tmr_count[has_pkg::TMR_WRITE] >= need_write;
    wire ok_rxinf  = !rd_rx_inf || tmr_count[has_pkg::TMR_RXPOP] >= has_pkg::WAIT_SHORT_CYC;
    wire ok_txinf  = !rd_tx_inf || tmr_count[has_pkg::TMR_TXSTAT] >= has_pkg::WAIT_SHORT_CYC;
    wire ok_drop   = !rd_drop || tmr_count[has_pkg::TMR_DROP] >= has_pkg::WAIT_LONG_CYC;
    wire ok_stat   = !(rd_rx_stat || rd_tx_stat)
                     || tmr_count[has_pkg::TMR_DPCTRL] >= has_pkg::WAIT_LONG_CYC;
    wire gap_ok    = !enforce || (ok_write && ok_rxinf && ok_txinf && ok_drop && ok_stat);

    // Launches: the real access once clear, else a dummy read if enabled
    wire launch_user  = (state == HM_WAIT) && gap_ok;
    wire launch_dummy = (state == HM_WAIT) && !gap_ok && dummy_mode;
    wire user_done    = (state == HM_RUN) && pin_done;
    wire ffwd_clear   = rd_dpctrl && ffwd_pending && !pin_rdata[has_pkg::FFWD_BIT];

    always_comb begin
        pin_req = cmd_req;
        if (launch_dummy) begin
            pin_req = '{write: 1'b0, fifo_sel: 1'b0, addr: has_pkg::DEV_BYTE_TEST, wdata: 32'h0000_0000};
        end
    end

    // Timer restarts at the end of each access that starts a wait
    always_comb begin
        restart = '0;
        restart[has_pkg::TMR_WRITE]  = user_done && cmd_req.write;
        restart[has_pkg::TMR_RXPOP]  = user_done && rd_rx_pop;
        restart[has_pkg::TMR_TXSTAT] = user_done && rd_tx_stat;
        restart[has_pkg::TMR_DROP]   = user_done && rd_drop;
        restart[has_pkg::TMR_DPCTRL] = user_done && ffwd_clear;
    end

    // Sequencer state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= HM_IDLE;
        end else begin
            case (state)
                HM_IDLE:  if (cmd_take) state <= HM_WAIT;
                HM_WAIT:  if (launch_user) state <= HM_RUN;
                          else if (launch_dummy) state <= HM_DUMMY;
                HM_RUN:   if (pin_done) state <= HM_IDLE;
                HM_DUMMY: if (pin_done) state <= HM_WAIT;
                default:  state <= HM_IDLE;
            endcase
        end
    end

    // Result, stall statistics and fast-forward tracking; a new arm beats a clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_rdata   <= 32'h0000_0000;
            stall_count  <= 32'h0000_0000;
            ffwd_pending <= 1'b0;
        end else begin
            if (user_done && is_rd) begin
                last_rdata <= pin_rdata;
            end
            if ((state == HM_WAIT || state == HM_DUMMY) && !gap_ok && stall_count != 32'hffff_ffff) begin
                stall_count <= stall_count + 32'h0000_0001;
            end
            if (user_done && wr_dpctrl && cmd_req.wdata[has_pkg::FFWD_BIT]) begin
                ffwd_pending <= 1'b1;
            end else if (user_done && ffwd_clear) begin
                ffwd_pending <= 1'b0;
            end
        end
    end

    has_gap_timer u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .restart (restart),
        .count   (tmr_count)
    );

    has_pin_cycle u_pins (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (launch_user || launch_dummy),
        .req     (pin_req),
        .data_in (dev_data_in),
        .pins    (pins),
        .busy    (pin_busy),
        .done    (pin_done),
        .rdata   (pin_rdata)
    );

    // Device pins straight from the cycle generator flops
    assign chip_select_n  = pins.chip_select_n;
    assign read_strobe_n  = pins.read_strobe_n;
    assign write_strobe_n = pins.write_strobe_n;
    assign fifo_sel       = pins.fifo_sel;
    assign dev_addr       = pins.addr;
    assign dev_data_out   = pins.data_out;
    assign dev_data_oe    = pins.data_oe;

    // Checks on the spacing actually produced
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    write_gap_a: assert property (launch_user && enforce && is_rd && !zero_class && !long_class
        |-> tmr_count[has_pkg::TMR_WRITE] >= 5'h09) else $error("short read after write too soon");
    long_gap_a: assert property (launch_user && enforce && is_rd && long_class
        |-> tmr_count[has_pkg::TMR_WRITE] >= 5'h11) else $error("long read after write too soon");
    rxinf_gap_a: assert property (launch_user && enforce && rd_rx_inf
        |-> tmr_count[has_pkg::TMR_RXPOP] >= 5'h09) else $error("rx info read too soon after pop");
    txinf_gap_a: assert property (launch_user && enforce && rd_tx_inf
        |-> tmr_count[has_pkg::TMR_TXSTAT] >= 5'h09) else $error("tx info read too soon");
    drop_gap_a: assert property (launch_user && enforce && rd_drop
        |-> tmr_count[has_pkg::TMR_DROP] >= 5'h11) else $error("drop counter reread too soon");
    status_gap_a: assert property (launch_user && enforce && (rd_rx_stat || rd_tx_stat)
        |-> tmr_count[has_pkg::TMR_DPCTRL] >= 5'h11) else $error("status FIFO read too soon");
    strobe_excl_a: assert property (!(read_strobe_n == 1'b0 && write_strobe_n == 1'b0)
        && (chip_select_n || !(read_strobe_n && write_strobe_n))) else $error("strobes overlap");
    cycle_len_a: assert property ((launch_user || launch_dummy) |=> !pin_done [*8] ##1 pin_done)
        else $error("device cycle not nine clocks");
    wait_bound_a: assert property ($rose(state == HM_WAIT) && !dummy_mode
        |-> ##[0:18] launch_user) else $error("wait did not end in time");
    restart_write_a: assert property (user_done && cmd_req.write
        |=> tmr_count[has_pkg::TMR_WRITE] == 5'h00) else $error("write timer not restarted");
    launch_idle_a: assert property ((launch_user || launch_dummy) |-> !pin_busy)
        else $error("launch while device cycle busy");

    write_cov: cover property (launch_user && cmd_req.write);
    stall_cov: cover property ((state == HM_WAIT) && !gap_ok ##[1:20] launch_user);
    dummy_cov: cover property (launch_dummy ##[1:30] launch_user);
    ffwd_cov:  cover property (restart[has_pkg::TMR_DPCTRL]);

endmodule

// >>> has_dev_model.sv
// Behavioural model of the device side of the parallel host bus
`timescale 1ns/1ps
module has_dev_model (
    input  wire logic        chip_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        fifo_sel,
    input  wire logic [7:0]  dev_addr,
    output logic      [31:0] dev_data_in
);
    logic [31:0] last_q = 32'h0;
    logic [7:0]  tx_level = 8'h0;
    logic [31:0] resp;

    // Read response: direct FIFO reads, FIFO level, else a word naming the offset
    assign resp = fifo_sel ? 32'hf1f00000 :
                  (dev_addr == has_pkg::DEV_TX_FIFO_INFO) ? {24'h0, tx_level} :
                  {24'h0d0000, dev_addr};
    // Data pins driven only during a selected read; otherwise inverse of last value
    assign dev_data_in = (!chip_select_n && !read_strobe_n) ? resp : ~last_q;
    always @(posedge read_strobe_n) last_q <= resp;
    // Level indication follows each write as its strobe falls; the reset rise of the pin is no write
    always @(negedge write_strobe_n) tx_level <= tx_level + 8'h1;
endmodule

// >>> testbench.sv
// Self-checking bench for the host access spacing controller
`timescale 1ns/1ps
module testbench;
    logic        sys_clk, rst, avs_read, avs_write;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, dev_data_in, dev_data_out, rd;
    logic [7:0]  dev_addr, n_wr;
    logic [31:0] stall0, wr_seen;
    logic        avs_waitrequest, chip_select_n, read_strobe_n, write_strobe_n, fifo_sel, dev_data_oe;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          dummies = 0;
    realtime     t_end = 0;
    realtime     gap = 0;

    has_host_ctrl has_host_ctrl_i (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .chip_select_n, .read_strobe_n, .write_strobe_n, .fifo_sel,
        .dev_addr, .dev_data_in, .dev_data_out, .dev_data_oe);
    has_dev_model has_dev_model_i (.chip_select_n, .read_strobe_n, .write_strobe_n, .fifo_sel,
        .dev_addr, .dev_data_in);

    // Clock at 50 MHz
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Gap from end of last strobe to start of a read; count filler reads
    always @(posedge read_strobe_n or posedge write_strobe_n) t_end = $realtime;
    always @(negedge read_strobe_n) begin
        gap = $realtime - t_end;
        if (dev_addr === has_pkg::DEV_BYTE_TEST) dummies++;
    end
    // Data seen on the pins at each write strobe
    always @(negedge write_strobe_n) wr_seen = dev_data_oe ? dev_data_out : 32'h0;
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_min(input string name, input realtime lim, input realtime seen);
        cmp_count++;
        if (!(seen >= lim)) begin
            miscompares++;
            $display("[FAIL] %s expected at least %0.1f seen %0.1f", name, lim, seen);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    // Order one device access; a second order is held by waitrequest until the first ends
    task automatic go(input logic [9:0] cmd);
        if (cmd[8]) n_wr++;
        av(1'b1, has_pkg::REG_CMD, {22'h0, cmd});
    endtask
    // Wait for idle, then fetch the last read data
    task automatic fin;
        do av(1'b0, has_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
        av(1'b0, has_pkg::REG_RDATA, 32'h0);
    endtask
    // One device access ordered through the command register
    task automatic acc(input logic [9:0] cmd);
        go(cmd);
        fin();
    endtask
    // Trigger access, then a restricted read ordered at once; check spacing and data
    task automatic pair(input logic [9:0] first, input logic [7:0] second, input realtime need);
        go(first);
        go({2'b00, second});
        fin();
        chk_min("gap", need, gap);
        chk_val("data", (second == has_pkg::DEV_TX_FIFO_INFO) ? {24'h0, n_wr} : {24'h0d0000, second}, rd);
    endtask

    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        n_wr = 8'h0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        av(1'b0, has_pkg::REG_CTRL, 32'h0);
        chk_val("ctrl", 32'h1, rd);
        av(1'b0, 3'h7, 32'h0);
        chk_val("unmapped", 32'h0, rd);
        pair(10'h184, 8'h84, 330);
        pair(10'h150, 8'h74, 165);
        pair(10'h100, 8'h9c, 330);
        pair(10'h000, 8'h7c, 165);
        pair(10'h040, 8'h7c, 165);
        pair(10'h048, 8'h80, 165);
        pair(10'h0a0, 8'ha0, 330);
        pair(10'h120, 8'h80, 165);
        acc(10'h200);
        chk_val("fifo", 32'hf1f00000, rd);
        av(1'b1, has_pkg::REG_WDATA, 32'h80000000);
        pair(10'h178, 8'h78, 165);
        go(10'h178);
        go(10'h078);
        go(10'h040);
        fin();
        chk_min("ffwd gap", 330, gap);
        chk_val("ffwd data", {24'h0d0000, 8'h40}, rd);
        chk_val("wdata pins", 32'h80000000, wr_seen);
        av(1'b0, has_pkg::REG_STATUS, 32'h0);
        chk_val("status", 32'h0, rd);
        av(1'b1, has_pkg::REG_CTRL, 32'h3);
        go(10'h184);
        dummies = 0;
        go(10'h084);
        fin();
        chk_min("dummies", 1, dummies);
        chk_val("dummy data", {24'h0d0000, 8'h84}, rd);
        av(1'b1, has_pkg::REG_CTRL, 32'h0);
        av(1'b0, has_pkg::REG_STALL, 32'h0);
        stall0 = rd;
        go(10'h184);
        go(10'h084);
        fin();
        av(1'b0, has_pkg::REG_STALL, 32'h0);
        chk_val("stall", stall0, rd);
        give_verdict();
    end
endmodule
